// ===== dv/sssc_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
module sssc_rail_model
(
   input wire logic aclk,
   input wire logic [3:0] fault_req,
   output logic io_ov_cmp,
   output logic io_uv_cmp,
   output logic gen_ov_cmp,
   output logic gen_uv_cmp
);
   // Comparators settle off the clock grid, so the synchronisers see a true async edge.
   initial {gen_uv_cmp, gen_ov_cmp, io_uv_cmp, io_ov_cmp} = 4'h0;
   always @(posedge aclk)
      {gen_uv_cmp, gen_ov_cmp, io_uv_cmp, io_ov_cmp} <= #13 fault_req;
endmodule : sssc_rail_model
`default_nettype wire

// ===== dv/sssc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sssc_top_properties
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic failsafe_enable,
   input wire logic io_ov_cmp,
   input wire logic io_ov_deglitch_sel,
   input wire logic gen_ov_enable,
   input wire sssc_pkg::sssc_src_type io_rail_source_select,
   input wire sssc_pkg::sssc_thr_type io_ov_threshold_code,
   input wire sssc_pkg::sssc_thr_type io_ov_threshold,
   input wire sssc_pkg::sssc_code_type core_threshold_offset,
   input wire sssc_pkg::sssc_code_type core_buck_offset,
   input wire logic [2:0] reg_switch_off,
   input wire logic [3:0] fault_active,
   input wire logic reset_out_n
);
   import sssc_pkg::*;
   logic [10:0] io_ov_run;
   logic [10:0] io_ov_lim;
   logic io_src_int;
   assign io_ov_lim = io_ov_deglitch_sel ? 11'h384 : 11'h1F4;
   assign io_src_int = io_rail_source_select inside {3'h1, 3'h2, 3'h3};
   // Counts how long the pin has been high with monitoring on; saturates to avoid wrap.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !io_ov_cmp || !failsafe_enable)
         io_ov_run <= 11'h000;
      else if (io_ov_run != 11'h7FF)
         io_ov_run <= io_ov_run + 11'h001;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_ramp_done;
      ##[1:500] core_buck_offset == core_threshold_offset;
   endsequence
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   a_target_limit: assert property (core_threshold_offset <= 5'h10)
      else $error("target beyond maximum code");
   a_ramp_step: assert property ($changed(core_buck_offset) |->
      core_buck_offset == $past(core_buck_offset) + 5'h01 ||
      core_buck_offset == $past(core_buck_offset) - 5'h01) else $error("buck offset jumped");
   a_ramp_reach: assert property ($changed(core_threshold_offset) |-> s_ramp_done)
      else $error("buck offset did not reach target in time");
   a_thr_copy: assert property ($past(aresetn) |->
      io_ov_threshold == $past(io_ov_threshold_code)) else $error("threshold not copied");
   a_fs_clears: assert property (!failsafe_enable |=> fault_active == 4'h0)
      else $error("fault active while monitoring off");
   a_gen_gated: assert property (!gen_ov_enable |=> !fault_active[2])
      else $error("general fault while disabled");
   a_dglt_min: assert property ($rose(fault_active[0]) |-> io_ov_run >= io_ov_lim)
      else $error("overvoltage flagged before filter time");
   a_dglt_max: assert property (io_ov_run == io_ov_lim + 11'h00C |-> fault_active[0])
      else $error("overvoltage not flagged after filter time");
   a_io_switch: assert property (fault_active[0] && failsafe_enable && io_src_int |=>
      reg_switch_off[io_rail_source_select - 3'h1]) else $error("regulator not switched off");
   a_ext_keep: assert property (fault_active == 4'h1 && !io_src_int |=>
      reg_switch_off == 3'h0) else $error("external source switched off");
   a_reset_cause: assert property ($fell(reset_out_n) |-> $past(fault_active != 4'h0))
      else $error("reset output without fault");
endmodule : sssc_top_properties
bind sssc_top sssc_top_properties props (.*);
`default_nettype wire

// ===== dv/test_supply_supervisor_svs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_supply_supervisor_svs_ctrl;
   import sssc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic safety_init_phase = 1'b0, failsafe_enable = 1'b0;
   logic io_ov_cmp, io_uv_cmp, gen_ov_cmp, gen_uv_cmp;
   sssc_src_type io_rail_source_select = 3'h1;
   logic gen_ov_enable = 1'b1, gen_uv_enable = 1'b1;
   sssc_thr_type io_ov_threshold_code = 8'h00, io_uv_threshold_code = 8'h00;
   sssc_thr_type gen_ov_threshold_code = 8'h00, gen_uv_threshold_code = 8'h00;
   logic io_ov_deglitch_sel = 1'b0, gen_ov_deglitch_sel = 1'b0;
   logic [1:0] io_uv_deglitch_sel = 2'h0, gen_uv_deglitch_sel = 2'h0;
   sssc_thr_type io_ov_threshold, io_uv_threshold, gen_ov_threshold, gen_uv_threshold;
   sssc_code_type core_threshold_offset, core_buck_offset, t, tgt;
   logic [2:0] reg_switch_off;
   logic [3:0] fault_active, fault_req = 4'h0;
   logic reset_out_n;
   logic [31:0] seed = 32'hA56AD6BE, rv;
   int fails = 0, compares = 0, cycles = 0, n;

   sssc_top dut (.*);
   sssc_rail_model rail (.*);

   always #25 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         end_of_test();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic int lim(input int m);
      logic [1:0] s;
      s = (m == 1) ? io_uv_deglitch_sel : gen_uv_deglitch_sel;
      if (m == 0)
         return io_ov_deglitch_sel ? 11'h384 : 11'h1F4;
      if (m == 2)
         return gen_ov_deglitch_sel ? 11'h384 : 11'h1F4;
      return (s == 2'h0) ? 11'h064 : (s == 2'h1) ? 11'h12C : (s == 2'h2) ? 11'h1F4 : 11'h320;
   endfunction : lim

   function automatic logic [2:0] exp_off(input int m, input logic [2:0] g);
      logic [2:0] s;
      s = (m == 0) ? io_rail_source_select : (m == 2) ? g : 3'h0;
      return (s inside {3'h1, 3'h2, 3'h3}) ? 3'h1 << (s - 3'h1) : 3'h0;
   endfunction : exp_off

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, busy, seen;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= seed[0];
      busy = 1'b1;
      while (busy)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         busy = !(s_axi_bvalid && s_axi_bready);
         seen = s_axi_bvalid;
         if (!busy)
            chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         s_axi_bready <= busy && (seen || s_axi_bready);
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, busy;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      busy = 1'b1;
      while (busy)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         busy = !s_axi_rvalid;
         if (!busy)
         begin
            chk("rdata", e, s_axi_rdata);
            chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
         end
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'b0;
         if (!busy)
            s_axi_rready <= 1'b0;
      end
   endtask : rd

   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 32'h00, 2'h0);
      rd(8'h04, 32'h1F, 2'h0);
      rd(8'h08, 32'h66, 2'h0);
      rd(8'h14, 32'h00, 2'h2);
      wr(8'h14, 32'h01, 2'h2);
      repeat (3)
      begin
         rv = xs();
         @(posedge aclk);
         io_ov_threshold_code <= rv[7:0];
         io_uv_threshold_code <= rv[15:8];
         gen_ov_threshold_code <= rv[23:16];
         gen_uv_threshold_code <= rv[31:24];
         repeat (2) @(negedge aclk);
         chk("thresholds", rv, {gen_uv_threshold, gen_ov_threshold, io_uv_threshold,
            io_ov_threshold});
      end
      $display("reset and threshold test done");
      wr(8'h00, 32'h08, 2'h0);
      wr(8'h04, 32'h17, 2'h0);
      @(negedge aclk);
      chk("target", 32'h0, {27'h0, core_threshold_offset});
      @(posedge aclk);
      safety_init_phase <= 1'b1;
      tgt = 5'h00;
      wr(8'h00, 32'h11, 2'h0);
      wr(8'h04, 32'h0E, 2'h0);
      for (int i = 0; i < 3; i++)
      begin
         rv = xs();
         t = (i == 0) ? 5'h10 : (i == 1) ? {1'b0, rv[3:0]} : 5'h00;
         wr(8'h00, {27'h0, t}, 2'h0);
         wr(8'h04, {27'h0, ~t ^ 5'h01}, 2'h0);
         repeat (2) @(negedge aclk);
         chk("target", {27'h0, tgt}, {27'h0, core_threshold_offset});
         rd(8'h0C, {7'h0, 1'b1, 3'h0, tgt, 3'h0, tgt, 8'h20}, 2'h0);
         wr(8'h04, {27'h0, ~t}, 2'h0);
         repeat (2) @(negedge aclk);
         chk("target", {27'h0, t}, {27'h0, core_threshold_offset});
         tgt = t;
         repeat (520) @(posedge aclk);
         @(negedge aclk);
         chk("buck", {27'h0, t}, {27'h0, core_buck_offset});
      end
      $display("scaling test done");
      for (int k = 0; k < 2; k++)
      begin
         @(posedge aclk);
         failsafe_enable <= k[0];
         gen_ov_enable <= 1'b0;
         gen_uv_enable <= 1'b0;
         fault_req <= k[0] ? 4'hC : 4'hF;
         repeat (1000) @(posedge aclk);
         @(negedge aclk);
         chk("masked", 32'h1, {27'h0, fault_active, reset_out_n});
         @(posedge aclk);
         fault_req <= 4'h0;
         gen_ov_enable <= 1'b1;
         gen_uv_enable <= 1'b1;
      end
      repeat (10) @(posedge aclk);
      $display("masking test done");
      for (int m = 0; m < 4; m++)
         for (int c = 0; c < 4; c++)
         begin
            rv = xs();
            @(posedge aclk);
            safety_init_phase <= 1'b1;
            wr(8'h08, {21'h0, rv[2:0], 8'h00} | (32'(c) << (2 * m)), 2'h0);
            @(posedge aclk);
            safety_init_phase <= 1'b0;
            io_rail_source_select <= rv[5:3];
            io_ov_deglitch_sel <= rv[6];
            gen_ov_deglitch_sel <= rv[7];
            io_uv_deglitch_sel <= rv[9:8];
            gen_uv_deglitch_sel <= rv[11:10];
            fault_req <= 4'h1 << m;
            n = 0;
            @(negedge aclk);
            while (fault_active[m] !== 1'b1 && n < 1000)
            begin
               @(negedge aclk);
               n++;
            end
            chk("deglitch", 32'h1, {31'h0, n >= lim(m) && n <= lim(m) + 12});
            repeat (12) @(negedge aclk);
            chk("reset_out_n", {31'h0, ~c[1]}, {31'h0, reset_out_n});
            chk("switch_off", {29'h0, exp_off(m, rv[2:0])}, {29'h0, reg_switch_off});
            @(posedge aclk);
            fault_req <= 4'h0;
            repeat (20) @(posedge aclk);
            @(negedge aclk);
            chk("cleared", 32'h1, {27'h0, fault_active,
               reg_switch_off == 3'h0 && reset_out_n});
            rd(8'h10, 32'h1 << m, 2'h0);
            wr(8'h10, 32'hF, 2'h0);
         end
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h08, 32'h66, 2'h0);
      $display("fault reaction test done");
      end_of_test();
   end
endmodule : test_supply_supervisor_svs_ctrl
`default_nettype wire

// ===== hdl/sssc_cfg.svh
`ifndef SSSC_CFG_SVH
`define SSSC_CFG_SVH

// Register byte offsets.
`define SSSC_OFF_TRIM 8'h00
`define SSSC_OFF_TRIM_INV 8'h04
`define SSSC_OFF_IMPACT 8'h08
`define SSSC_OFF_STATUS 8'h0C
`define SSSC_OFF_FLAGS 8'h10

// Field positions in the impact register.
`define SSSC_IMP_IO_OV 1:0
`define SSSC_IMP_IO_UV 3:2
`define SSSC_IMP_GEN_OV 5:4
`define SSSC_IMP_GEN_UV 7:6
`define SSSC_IMP_GEN_SRC 10:8
`define SSSC_IMP_ASSERT_BIT 1

// Field positions in the status register.
`define SSSC_ST_BUSY 4
`define SSSC_ST_REJECT 5
`define SSSC_ST_TARGET 12:8
`define SSSC_ST_OFFSET 20:16
`define SSSC_ST_INIT 24

// Reset values.
`define SSSC_RST_TRIM 5'h00
`define SSSC_RST_TRIM_INV 5'h1F
`define SSSC_RST_OV_IMPACT 2'h2
`define SSSC_RST_UV_IMPACT 2'h1
`define SSSC_RST_GEN_SRC 3'h0
`define SSSC_TRIM_MAX 5'h10

// Monitor indices.
`define SSSC_MON_IO_OV 0
`define SSSC_MON_IO_UV 1
`define SSSC_MON_GEN_OV 2
`define SSSC_MON_GEN_UV 3
`define SSSC_MON_COUNT 4

// Regulator source codes; every other code means an external regulator.
`define SSSC_SRC_PRE 3'h1
`define SSSC_SRC_LIN 3'h2
`define SSSC_SRC_AUX 3'h3
`define SSSC_OFF_PRE 0
`define SSSC_OFF_LIN 1
`define SSSC_OFF_AUX 2

// AXI responses.
`define SSSC_RESP_OKAY 2'h0
`define SSSC_RESP_SLVERR 2'h2

// Timing.
`define SSSC_CLK_PERIOD_NS 50
`define SSSC_OV_DGLT_SHORT_NS 25000
`define SSSC_OV_DGLT_LONG_NS 45000
`define SSSC_UV_DGLT_0_NS 5000
`define SSSC_UV_DGLT_1_NS 15000
`define SSSC_UV_DGLT_2_NS 25000
`define SSSC_UV_DGLT_3_NS 40000
`define SSSC_CORE_OV_FILTER_NS 25000
`define SSSC_CYC_UP(t) (((t) + `SSSC_CLK_PERIOD_NS - 1) / `SSSC_CLK_PERIOD_NS)
`define SSSC_RAMP_STEP_CYC \
   (`SSSC_CORE_OV_FILTER_NS / `SSSC_CLK_PERIOD_NS / 32'(`SSSC_TRIM_MAX))

`endif

// ===== hdl/sssc_pkg.sv
package sssc_pkg;

   typedef logic [4:0] sssc_code_type;
   typedef logic [1:0] sssc_impact_type;
   typedef logic [7:0] sssc_thr_type;
   typedef logic [2:0] sssc_src_type;

   typedef enum logic {SSSC_SCALE_IDLE, SSSC_SCALE_RAMP} sssc_scale_state_type;

endpackage : sssc_pkg

// ===== hdl/sssc_top.sv
`include "sssc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sssc_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic safety_init_phase,
   input wire logic failsafe_enable,
   input wire logic io_ov_cmp,
   input wire logic io_uv_cmp,
   input wire logic gen_ov_cmp,
   input wire logic gen_uv_cmp,
   input wire sssc_pkg::sssc_src_type io_rail_source_select,
   input wire logic gen_ov_enable,
   input wire logic gen_uv_enable,
   input wire sssc_pkg::sssc_thr_type io_ov_threshold_code,
   input wire sssc_pkg::sssc_thr_type io_uv_threshold_code,
   input wire sssc_pkg::sssc_thr_type gen_ov_threshold_code,
   input wire sssc_pkg::sssc_thr_type gen_uv_threshold_code,
   input wire logic io_ov_deglitch_sel,
   input wire logic [1:0] io_uv_deglitch_sel,
   input wire logic gen_ov_deglitch_sel,
   input wire logic [1:0] gen_uv_deglitch_sel,
   output sssc_pkg::sssc_thr_type io_ov_threshold,
   output sssc_pkg::sssc_thr_type io_uv_threshold,
   output sssc_pkg::sssc_thr_type gen_ov_threshold,
   output sssc_pkg::sssc_thr_type gen_uv_threshold,
   output sssc_pkg::sssc_code_type core_threshold_offset,
   output sssc_pkg::sssc_code_type core_buck_offset,
   output logic [2:0] reg_switch_off,
   output logic [3:0] fault_active,
   output logic reset_out_n
);
   import sssc_pkg::*;

   localparam int CNT_W = 10;
   localparam int STEP_W = 8;

   initial
   begin
      if (`SSSC_CYC_UP(`SSSC_OV_DGLT_LONG_NS) >= (1 << CNT_W))
         $error("Deglitch counter too narrow.");
      if (`SSSC_RAMP_STEP_CYC < 1 || `SSSC_RAMP_STEP_CYC >= (1 << STEP_W))
         $error("Ramp step counter out of range.");
   end

   // Register bus state.
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] wr_mask;

   // Configuration and status state.
   sssc_code_type trim_code;
   sssc_code_type trim_inv;
   sssc_impact_type io_ov_reset_effect;
   sssc_impact_type io_uv_reset_effect;
   sssc_impact_type gen_ov_reset_effect;
   sssc_impact_type gen_uv_reset_effect;
   sssc_src_type gen_monitor_source_reg;
   sssc_code_type scale_target;
   logic scale_reject;
   logic [3:0] fault_sticky;
   sssc_scale_state_type scale_state;
   logic [STEP_W-1:0] step_cnt;

   // Monitor state.
   logic [3:0] cmp_raw;
   logic [3:0] cmp_meta;
   logic [3:0] cmp_sync;
   logic [3:0] mon_en;
   logic [3:0] filt;
   logic [3:0] filt_q;
   logic [CNT_W-1:0] lim [`SSSC_MON_COUNT];
   logic [3:0] reset_sel;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         wr_mask[i*8 +: 8] = {8{w_strb[i]}};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end
      else if (s_axi_awvalid && !aw_held)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else if (s_axi_wvalid && !w_held)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSSC_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == `SSSC_OFF_TRIM || aw_addr == `SSSC_OFF_TRIM_INV ||
             aw_addr == `SSSC_OFF_IMPACT || aw_addr == `SSSC_OFF_STATUS ||
             aw_addr == `SSSC_OFF_FLAGS)
            s_axi_bresp <= `SSSC_RESP_OKAY;
         else
            s_axi_bresp <= `SSSC_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Settings other than the generic monitor source written outside the init phase are dropped silently with OKAY.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trim_code <= `SSSC_RST_TRIM;
         trim_inv <= `SSSC_RST_TRIM_INV;
      end
      else if (wr_fire && safety_init_phase)
      begin
         if (aw_addr == `SSSC_OFF_TRIM)
            trim_code <= sssc_code_type'((32'(trim_code) & ~wr_mask) | (w_data & wr_mask));
         if (aw_addr == `SSSC_OFF_TRIM_INV)
            trim_inv <= sssc_code_type'((32'(trim_inv) & ~wr_mask) | (w_data & wr_mask));
      end
   end

   // The inverse write is the trigger; a code above the table end is refused too.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scale_target <= `SSSC_RST_TRIM;
         scale_reject <= 1'b0;
      end
      else if (wr_fire && safety_init_phase && aw_addr == `SSSC_OFF_TRIM_INV && w_strb[0])
      begin
         if (w_data[4:0] == ~trim_code && trim_code <= `SSSC_TRIM_MAX)
         begin
            scale_target <= trim_code;
            scale_reject <= 1'b0;
         end
         else
            scale_reject <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         io_ov_reset_effect <= `SSSC_RST_OV_IMPACT;
         io_uv_reset_effect <= `SSSC_RST_UV_IMPACT;
         gen_ov_reset_effect <= `SSSC_RST_OV_IMPACT;
         gen_uv_reset_effect <= `SSSC_RST_UV_IMPACT;
      end
      else if (wr_fire && safety_init_phase && aw_addr == `SSSC_OFF_IMPACT && w_strb[0])
      begin
         io_ov_reset_effect <= w_data[`SSSC_IMP_IO_OV];
         io_uv_reset_effect <= w_data[`SSSC_IMP_IO_UV];
         gen_ov_reset_effect <= w_data[`SSSC_IMP_GEN_OV];
         gen_uv_reset_effect <= w_data[`SSSC_IMP_GEN_UV];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gen_monitor_source_reg <= `SSSC_RST_GEN_SRC;
      else if (wr_fire && aw_addr == `SSSC_OFF_IMPACT && w_strb[1])
         gen_monitor_source_reg <= w_data[`SSSC_IMP_GEN_SRC];
   end

   // Write-one-to-clear; a new fault edge in the same cycle keeps its flag.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fault_sticky <= 4'h0;
      else if (wr_fire && aw_addr == `SSSC_OFF_FLAGS && w_strb[0])
         fault_sticky <= (fault_sticky & ~w_data[3:0]) | (filt & ~filt_q);
      else
         fault_sticky <= fault_sticky | (filt & ~filt_q);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SSSC_RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SSSC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         unique case (s_axi_araddr)
            `SSSC_OFF_TRIM: s_axi_rdata <= 32'(trim_code);
            `SSSC_OFF_TRIM_INV: s_axi_rdata <= 32'(trim_inv);
            `SSSC_OFF_IMPACT:
               s_axi_rdata <= {21'h000000, gen_monitor_source_reg, gen_uv_reset_effect,
                               gen_ov_reset_effect, io_uv_reset_effect, io_ov_reset_effect};
            `SSSC_OFF_STATUS:
               s_axi_rdata <= {7'h00, safety_init_phase, 3'h0, core_buck_offset,
                               3'h0, scale_target, 2'h0, scale_reject,
                               scale_state == SSSC_SCALE_RAMP, filt};
            `SSSC_OFF_FLAGS: s_axi_rdata <= {28'h0000000, fault_sticky};
            default: s_axi_rresp <= `SSSC_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Monitor thresholds move the moment the target is accepted.
   assign core_threshold_offset = scale_target;

   // Ramp one code per step so sixteen codes fit inside the core OV filter time.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scale_state <= SSSC_SCALE_IDLE;
         step_cnt <= '0;
         core_buck_offset <= `SSSC_RST_TRIM;
      end
      else
      begin
         unique case (scale_state)
            SSSC_SCALE_IDLE:
            begin
               step_cnt <= '0;
               if (core_buck_offset != scale_target)
                  scale_state <= SSSC_SCALE_RAMP;
            end
            SSSC_SCALE_RAMP:
            begin
               if (core_buck_offset == scale_target)
                  scale_state <= SSSC_SCALE_IDLE;
               else if (step_cnt == STEP_W'(`SSSC_RAMP_STEP_CYC - 1))
               begin
                  step_cnt <= '0;
                  if (core_buck_offset < scale_target)
                     core_buck_offset <= core_buck_offset + 5'h01;
                  else
                     core_buck_offset <= core_buck_offset - 5'h01;
               end
               else
                  step_cnt <= step_cnt + STEP_W'(1);
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         io_ov_threshold <= 8'h00;
         io_uv_threshold <= 8'h00;
         gen_ov_threshold <= 8'h00;
         gen_uv_threshold <= 8'h00;
      end
      else
      begin
         io_ov_threshold <= io_ov_threshold_code;
         gen_ov_threshold <= gen_ov_threshold_code;
         io_uv_threshold <= io_uv_threshold_code;
         gen_uv_threshold <= gen_uv_threshold_code;
      end
   end

   assign cmp_raw = {gen_uv_cmp, gen_ov_cmp, io_uv_cmp, io_ov_cmp};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_meta <= 4'h0;
         cmp_sync <= 4'h0;
      end
      else
      begin
         cmp_meta <= cmp_raw;
         cmp_sync <= cmp_meta;
      end
   end

   always_comb
   begin
      mon_en = {4{failsafe_enable}};
      mon_en[`SSSC_MON_GEN_OV] = failsafe_enable && gen_ov_enable;
      mon_en[`SSSC_MON_GEN_UV] = failsafe_enable && gen_uv_enable;
      lim[`SSSC_MON_IO_OV] = io_ov_deglitch_sel ?
         CNT_W'(`SSSC_CYC_UP(`SSSC_OV_DGLT_LONG_NS)) :
         CNT_W'(`SSSC_CYC_UP(`SSSC_OV_DGLT_SHORT_NS));
      lim[`SSSC_MON_GEN_OV] = gen_ov_deglitch_sel ?
         CNT_W'(`SSSC_CYC_UP(`SSSC_OV_DGLT_LONG_NS)) :
         CNT_W'(`SSSC_CYC_UP(`SSSC_OV_DGLT_SHORT_NS));
      lim[`SSSC_MON_IO_UV] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_0_NS));
      lim[`SSSC_MON_GEN_UV] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_0_NS));
      for (int m = `SSSC_MON_IO_UV; m <= `SSSC_MON_GEN_UV; m += 2)
      begin
         unique case (m == `SSSC_MON_IO_UV ? io_uv_deglitch_sel : gen_uv_deglitch_sel)
            2'h0: lim[m] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_0_NS));
            2'h1: lim[m] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_1_NS));
            2'h2: lim[m] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_2_NS));
            2'h3: lim[m] = CNT_W'(`SSSC_CYC_UP(`SSSC_UV_DGLT_3_NS));
         endcase
      end
   end

   // A fault is declared after its condition has held for the whole filter
   // time and is released as soon as the synchronised comparator drops.
   for (genvar g = 0; g < `SSSC_MON_COUNT; g++)
   begin : deglitch
      logic [CNT_W-1:0] cnt;
      always_ff @(posedge aclk)
      begin
         if (!aresetn || !mon_en[g] || !cmp_sync[g])
         begin
            cnt <= '0;
            filt[g] <= 1'b0;
         end
         else if (cnt != lim[g] - CNT_W'(1))
            cnt <= cnt + CNT_W'(1);
         else
            filt[g] <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         filt_q <= 4'h0;
      else
         filt_q <= filt;
   end

   assign fault_active = filt;

   // Only the upper impact bit counts, so the reserved 01 code has no reset effect.
   always_comb
   begin
      reset_sel[`SSSC_MON_IO_OV] = io_ov_reset_effect[`SSSC_IMP_ASSERT_BIT];
      reset_sel[`SSSC_MON_IO_UV] = io_uv_reset_effect[`SSSC_IMP_ASSERT_BIT];
      reset_sel[`SSSC_MON_GEN_OV] = gen_ov_reset_effect[`SSSC_IMP_ASSERT_BIT];
      reset_sel[`SSSC_MON_GEN_UV] = gen_uv_reset_effect[`SSSC_IMP_ASSERT_BIT];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         reset_out_n <= 1'b1;
      else
         reset_out_n <= !(|(filt & reset_sel));
   end

   // External sources match no code, so no switch-off bit is raised for them.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         reg_switch_off <= 3'h0;
      else
      begin
         reg_switch_off[`SSSC_OFF_PRE] <=
            (filt[`SSSC_MON_IO_OV] && io_rail_source_select == `SSSC_SRC_PRE) ||
            (filt[`SSSC_MON_GEN_OV] && gen_monitor_source_reg == `SSSC_SRC_PRE);
         reg_switch_off[`SSSC_OFF_LIN] <=
            (filt[`SSSC_MON_IO_OV] && io_rail_source_select == `SSSC_SRC_LIN) ||
            (filt[`SSSC_MON_GEN_OV] && gen_monitor_source_reg == `SSSC_SRC_LIN);
         reg_switch_off[`SSSC_OFF_AUX] <=
            (filt[`SSSC_MON_IO_OV] && io_rail_source_select == `SSSC_SRC_AUX) ||
            (filt[`SSSC_MON_GEN_OV] && gen_monitor_source_reg == `SSSC_SRC_AUX);
      end
   end

endmodule : sssc_top

`default_nettype wire
